// [hw/flls_consts.vh]
`ifndef FLLS_CONSTS_VH
`define FLLS_CONSTS_VH

// Register byte offsets
`define FLLS_REG_CTRL      8'h00
`define FLLS_REG_STATUS    8'h04
`define FLLS_REG_DWELL     8'h08
`define FLLS_REG_RANGE     8'h0C
`define FLLS_REG_LENGTH    8'h10
`define FLLS_REG_INDEX     8'h14
`define FLLS_REG_CMD       8'h18
`define FLLS_REG_EDIT_ADDR 8'h1C
`define FLLS_REG_FREQ      8'h20
`define FLLS_REG_LEVEL     8'h24
`define FLLS_REG_FILL_CFG  8'h28
`define FLLS_REG_FILL_ST   8'h2C
`define FLLS_REG_FILL_INC  8'h30

// Control fields
`define FLLS_CTRL_EN       0
`define FLLS_CTRL_MODE_LO  1
`define FLLS_CTRL_MODE_HI  3
`define FLLS_CTRL_NEG      4

// Cycle modes
`define FLLS_MODE_AUTO     3'h0
`define FLLS_MODE_SINGLE   3'h1
`define FLLS_MODE_STEP     3'h2
`define FLLS_MODE_XSINGLE  3'h3
`define FLLS_MODE_XSTEP    3'h4

// Command bits (write one to act) and entry count field
`define FLLS_CMD_RESET     0
`define FLLS_CMD_EXEC      1
`define FLLS_CMD_LEARN     2
`define FLLS_CMD_INSERT    3
`define FLLS_CMD_DELETE    4
`define FLLS_CMD_FILL      5
`define FLLS_CMD_WRITE     6
`define FLLS_CMD_CNT_LO    8
`define FLLS_CMD_CNT_HI    15

// Reset value and settling offset
`define FLLS_DWELL_RST     32'h0000_0032
`define FLLS_HW_SETTLE     8'h04

`endif

// [hw/flls_top.v]
`timescale 1ns/10ps
// Behaviour
// [RQ1] Timed modes hold each entry for dwell
// [RQ2] Step modes ignore dwell time
// [RQ3] Step entry lasts trigger to trigger
// [RQ4] Dwell is total step incl settling
// [RQ5] Reset returns position to start
// [RQ6] Manual step: index set directly, output
// [RQ7] Learn computes settings for every entry
// [RQ8] Stored settings reused on enable
// [RQ9] No settings: learn before processing
// [RQ10] Only start..stop range is processed
// [RQ11] Trigger edge chosen by polarity
// [RQ12] Entry is frequency plus level, variable length
// [RQ13] Insert shifts later entries upward
// [RQ14] Range delete removes count from mark
// [RQ15] Fill writes start plus increments
// [RQ16] Fill computes entries only on command
// [RQ17] Auto mode wraps to range start
// [RQ18] Single modes do one pass, stop
// [RQ19] One entry per external edge
// [RQ20] Range clamped to valid entries
module flls_top #(
    parameter AW = 6,
    parameter DEPTH = 64
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_arst_n,
    // Wishbone slave
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [7:0]  i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    output wire [31:0] o_wb_dat,
    output wire        o_wb_ack,
    // External trigger
    input  wire        i_instrument_trigger_input,
    // Output entry
    output wire [31:0] o_freq,
    output wire [15:0] o_level,
    output wire [15:0] o_hw_setting,
    output wire        o_busy,
    output wire        o_settled
);
`include "flls_consts.vh"

    localparam ST_IDLE  = 3'h0;
    localparam ST_LEARN = 3'h1;
    localparam ST_RUN   = 3'h2;
    localparam ST_WAIT  = 3'h3;
    localparam ST_EDIT  = 3'h4;

    reg [31:0]   freq_mem [0:DEPTH-1];
    reg [15:0]   lvl_mem  [0:DEPTH-1];
    reg [15:0]   hws_mem  [0:DEPTH-1];

    reg [4:0]    ctrl_ff;
    reg [31:0]   dwell_ff;
    reg [AW-1:0] start_ff;
    reg [AW-1:0] stop_ff;
    reg [AW:0]   len_ff;
    reg [AW-1:0] idx_ff;
    reg [AW-1:0] eaddr_ff;
    reg [31:0]   efreq_ff;
    reg [15:0]   elvl_ff;
    reg [AW+1:0] fill_cfg_ff;
    reg [31:0]   fill_st_ff;
    reg [31:0]   fill_inc_ff;
    reg          learned_ff;
    reg [2:0]    state_ff;
    reg [31:0]   tmr_ff;
    reg          trg_ff;
    reg          ack_ff;
    reg [31:0]   rdat_ff;
    reg [31:0]   ofreq_ff;
    reg [15:0]   olvl_ff;
    reg [15:0]   ohws_ff;
    reg [2:0]    eop_ff;
    reg [AW:0]   ecnt_ff;
    reg [AW-1:0] eptr_ff;
    reg [31:0]   fval_ff;
    reg [AW-1:0] lptr_ff;

    localparam EOP_INS = 3'h1;
    localparam EOP_DEL = 3'h2;
    localparam EOP_FIL = 3'h3;

    wire [2:0] mode    = ctrl_ff[`FLLS_CTRL_MODE_HI:`FLLS_CTRL_MODE_LO];
    wire       enable  = ctrl_ff[`FLLS_CTRL_EN];
    wire       step_md = (mode == `FLLS_MODE_STEP) || (mode == `FLLS_MODE_XSTEP);
    wire       ext_md  = (mode == `FLLS_MODE_XSINGLE) || (mode == `FLLS_MODE_XSTEP);

    // Bus access accepted once; ack drops the cycle after
    wire       wb_hit = i_wb_cyc && i_wb_stb && !ack_ff;
    wire       wb_wr  = wb_hit && i_wb_we;
    wire       cmd_wr = wb_wr && (i_wb_adr == `FLLS_REG_CMD) && i_wb_sel[0];
    wire       c_rst  = cmd_wr && i_wb_dat[`FLLS_CMD_RESET];
    wire       c_exec = cmd_wr && i_wb_dat[`FLLS_CMD_EXEC];
    wire       c_lrn  = cmd_wr && i_wb_dat[`FLLS_CMD_LEARN];
    wire [7:0] c_cnt  = i_wb_dat[`FLLS_CMD_CNT_HI:`FLLS_CMD_CNT_LO];

    // Edge of the selected polarity on the trigger pin
    wire trg_edge = ctrl_ff[`FLLS_CTRL_NEG] ? (trg_ff && !i_instrument_trigger_input)
                                            : (!trg_ff && i_instrument_trigger_input); // [RQ11]

    // Effective range, clamped to existing entries
    wire [AW:0]   last_ix = (len_ff == {(AW+1){1'b0}}) ? {(AW+1){1'b0}}
                                                       : len_ff - 1'b1;
    wire [AW-1:0] stop_c  = ({1'b0, stop_ff} > last_ix) ? last_ix[AW-1:0] : stop_ff; // [RQ20]
    wire [AW-1:0] start_c = (start_ff > stop_c) ? stop_c : start_ff; // [RQ20]
    wire          at_end  = (idx_ff >= stop_c);
    wire [AW-1:0] idx_nx  = at_end ? start_c : idx_ff + 1'b1; // [RQ10] [RQ17]

    // Dwell counts whole step, settling included; floor of one cycle
    wire [31:0] dwell_c = (dwell_ff == 32'h0) ? 32'h1 : dwell_ff; // [RQ4]

    // Manual index kept inside the processed range
    wire [AW-1:0] wr_idx = (i_wb_dat[AW-1:0] < start_c) ? start_c
                         : (i_wb_dat[AW-1:0] > stop_c) ? stop_c : i_wb_dat[AW-1:0];

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0;
            trg_ff  <= 1'b0;
        end else begin
            ack_ff <= wb_hit;
            trg_ff <= i_instrument_trigger_input;
            if (wb_hit && !i_wb_we) begin
                if (i_wb_adr == `FLLS_REG_CTRL) begin
                    rdat_ff <= {27'h0, ctrl_ff};
                end else if (i_wb_adr == `FLLS_REG_STATUS) begin
                    rdat_ff <= {24'h0, learned_ff, 2'h0, eop_ff != 3'h0, 1'b0, state_ff};
                end else if (i_wb_adr == `FLLS_REG_DWELL) begin
                    rdat_ff <= dwell_ff;
                end else if (i_wb_adr == `FLLS_REG_RANGE) begin
                    rdat_ff <= {{(16-AW){1'b0}}, stop_ff, {(16-AW){1'b0}}, start_ff};
                end else if (i_wb_adr == `FLLS_REG_LENGTH) begin
                    rdat_ff <= {{(31-AW){1'b0}}, len_ff};
                end else if (i_wb_adr == `FLLS_REG_INDEX) begin
                    rdat_ff <= {{(32-AW){1'b0}}, idx_ff};
                end else if (i_wb_adr == `FLLS_REG_EDIT_ADDR) begin
                    rdat_ff <= {{(32-AW){1'b0}}, eaddr_ff};
                end else if (i_wb_adr == `FLLS_REG_FREQ) begin
                    rdat_ff <= freq_mem[eaddr_ff];
                end else if (i_wb_adr == `FLLS_REG_LEVEL) begin
                    rdat_ff <= {16'h0, lvl_mem[eaddr_ff]};
                end else if (i_wb_adr == `FLLS_REG_FILL_CFG) begin
                    rdat_ff <= {{(30-AW){1'b0}}, fill_cfg_ff};
                end else if (i_wb_adr == `FLLS_REG_FILL_ST) begin
                    rdat_ff <= fill_st_ff;
                end else if (i_wb_adr == `FLLS_REG_FILL_INC) begin
                    rdat_ff <= fill_inc_ff;
                end else begin
                    rdat_ff <= 32'h0;
                end
            end
        end
    end

    // Plain configuration registers; fill values only stored here
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_ff     <= 5'h0;
            dwell_ff    <= `FLLS_DWELL_RST;
            start_ff    <= {AW{1'b0}};
            stop_ff     <= {AW{1'b1}};
            eaddr_ff    <= {AW{1'b0}};
            efreq_ff    <= 32'h0;
            elvl_ff     <= 16'h0;
            fill_cfg_ff <= {(AW+2){1'b0}};
            fill_st_ff  <= 32'h0;
            fill_inc_ff <= 32'h0;
        end else if (wb_wr) begin
            if (i_wb_adr == `FLLS_REG_CTRL) begin
                ctrl_ff <= i_wb_dat[4:0];
            end else if (i_wb_adr == `FLLS_REG_DWELL) begin
                dwell_ff <= i_wb_dat;
            end else if (i_wb_adr == `FLLS_REG_RANGE) begin
                start_ff <= i_wb_dat[AW-1:0];
                stop_ff  <= i_wb_dat[16+AW-1:16];
            end else if (i_wb_adr == `FLLS_REG_EDIT_ADDR) begin
                eaddr_ff <= i_wb_dat[AW-1:0];
            end else if (i_wb_adr == `FLLS_REG_FREQ) begin
                efreq_ff <= i_wb_dat;
            end else if (i_wb_adr == `FLLS_REG_LEVEL) begin
                elvl_ff <= i_wb_dat[15:0];
            end else if (i_wb_adr == `FLLS_REG_FILL_CFG) begin
                fill_cfg_ff <= i_wb_dat[AW+1:0];
            end else if (i_wb_adr == `FLLS_REG_FILL_ST) begin
                fill_st_ff <= i_wb_dat;
            end else if (i_wb_adr == `FLLS_REG_FILL_INC) begin
                fill_inc_ff <= i_wb_dat;
            end
        end
    end

    // Table edit engine: one entry moved per cycle, list blocked meanwhile
    always @(posedge i_clk) begin
        if (eop_ff == EOP_INS) begin
            // Walk down from top so nothing is overwritten early
            freq_mem[eptr_ff + ecnt_ff[AW-1:0]] <= freq_mem[eptr_ff];
            lvl_mem[eptr_ff + ecnt_ff[AW-1:0]]  <= lvl_mem[eptr_ff];
            if (eptr_ff < eaddr_ff + ecnt_ff[AW-1:0]) begin
                freq_mem[eptr_ff] <= 32'h0;
                lvl_mem[eptr_ff]  <= 16'h0;
            end
        end else if (eop_ff == EOP_DEL) begin
            freq_mem[eptr_ff] <= freq_mem[eptr_ff + ecnt_ff[AW-1:0]];
            lvl_mem[eptr_ff]  <= lvl_mem[eptr_ff + ecnt_ff[AW-1:0]];
        end else if (eop_ff == EOP_FIL) begin
            if (fill_cfg_ff[AW+1]) begin
                lvl_mem[eptr_ff] <= fval_ff[15:0]; // [RQ15]
            end else begin
                freq_mem[eptr_ff] <= fval_ff; // [RQ15]
            end
        end else if (cmd_wr && i_wb_dat[`FLLS_CMD_WRITE] && state_ff == ST_IDLE) begin
            freq_mem[eaddr_ff] <= efreq_ff; // [RQ12]
            lvl_mem[eaddr_ff]  <= elvl_ff;
        end
        if (state_ff == ST_LEARN) begin
            // Settings derived per entry: level plus fixed settling offset
            hws_mem[lptr_ff] <= lvl_mem[lptr_ff] + {8'h0, `FLLS_HW_SETTLE}; // [RQ7]
        end
    end

    // Sequencer and edit control
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff   <= ST_IDLE;
            len_ff     <= {(AW+1){1'b0}};
            idx_ff     <= {AW{1'b0}};
            tmr_ff     <= 32'h0;
            learned_ff <= 1'b0;
            eop_ff     <= 3'h0;
            ecnt_ff    <= {(AW+1){1'b0}};
            eptr_ff    <= {AW{1'b0}};
            fval_ff    <= 32'h0;
            lptr_ff    <= {AW{1'b0}};
        end else begin
            case (state_ff)
            ST_IDLE: begin
                if (cmd_wr && i_wb_dat[`FLLS_CMD_INSERT] && len_ff + c_cnt <= DEPTH) begin
                    eop_ff   <= EOP_INS; // [RQ13]
                    ecnt_ff  <= c_cnt[AW:0];
                    eptr_ff  <= len_ff[AW-1:0] - 1'b1;
                    len_ff   <= len_ff + c_cnt[AW:0];
                    state_ff <= ST_EDIT;
                    learned_ff <= 1'b0;
                end else if (cmd_wr && i_wb_dat[`FLLS_CMD_DELETE] && eaddr_ff + c_cnt <= len_ff) begin
                    eop_ff   <= EOP_DEL; // [RQ14]
                    ecnt_ff  <= c_cnt[AW:0];
                    eptr_ff  <= eaddr_ff;
                    len_ff   <= len_ff - c_cnt[AW:0];
                    state_ff <= ST_EDIT;
                    learned_ff <= 1'b0;
                end else if (cmd_wr && i_wb_dat[`FLLS_CMD_FILL]) begin
                    eop_ff   <= EOP_FIL; // [RQ16]
                    ecnt_ff  <= c_cnt[AW:0];
                    eptr_ff  <= fill_cfg_ff[AW-1:0];
                    fval_ff  <= fill_st_ff;
                    state_ff <= ST_EDIT;
                    learned_ff <= 1'b0;
                end else if (cmd_wr && i_wb_dat[`FLLS_CMD_WRITE]) begin
                    if (eaddr_ff >= len_ff) begin
                        len_ff <= {1'b0, eaddr_ff} + 1'b1; // [RQ12]
                    end
                    learned_ff <= 1'b0;
                end else if (c_lrn || (enable && !learned_ff && len_ff != 0)) begin
                    lptr_ff  <= {AW{1'b0}}; // [RQ7] [RQ9]
                    state_ff <= ST_LEARN;
                end else if (enable && learned_ff) begin
                    idx_ff   <= start_c; // [RQ8]
                    tmr_ff   <= dwell_c;
                    state_ff <= (mode == `FLLS_MODE_AUTO) ? ST_RUN : ST_WAIT;
                end
            end
            ST_EDIT: begin
                if (eop_ff == EOP_INS) begin
                    if (eptr_ff == eaddr_ff || ecnt_ff == 0) begin
                        eop_ff <= 3'h0;
                        state_ff <= ST_IDLE;
                    end
                    eptr_ff <= eptr_ff - 1'b1;
                end else if (eop_ff == EOP_DEL) begin
                    if ({1'b0, eptr_ff} + 1'b1 >= len_ff || ecnt_ff == 0) begin
                        eop_ff <= 3'h0;
                        state_ff <= ST_IDLE;
                    end
                    eptr_ff <= eptr_ff + 1'b1;
                end else begin
                    fval_ff <= fval_ff + fill_inc_ff; // [RQ15]
                    eptr_ff <= eptr_ff + 1'b1;
                    ecnt_ff <= ecnt_ff - 1'b1;
                    if (ecnt_ff <= 1 || {1'b0, eptr_ff} + 1'b1 >= len_ff) begin
                        eop_ff <= 3'h0;
                        state_ff <= ST_IDLE;
                    end
                end
            end
            ST_LEARN: begin
                lptr_ff <= lptr_ff + 1'b1;
                if ({1'b0, lptr_ff} + 1'b1 >= len_ff) begin
                    learned_ff <= 1'b1; // [RQ7]
                    state_ff   <= ST_IDLE;
                end
            end
            default: begin
                // ST_RUN and ST_WAIT
                if (!enable) begin
                    state_ff <= ST_IDLE;
                end else if (c_rst) begin
                    idx_ff <= start_c; // [RQ5]
                    tmr_ff <= dwell_c;
                    if (mode == `FLLS_MODE_SINGLE || mode == `FLLS_MODE_XSINGLE) begin
                        state_ff <= ST_WAIT;
                    end
                end else if (mode == `FLLS_MODE_STEP) begin
                    if (wb_wr && i_wb_adr == `FLLS_REG_INDEX) begin
                        idx_ff <= wr_idx; // [RQ6] [RQ3]
                    end
                end else if (mode == `FLLS_MODE_XSTEP) begin
                    if (trg_edge) begin
                        idx_ff <= idx_nx; // [RQ19] [RQ3] [RQ2]
                    end
                end else if (state_ff == ST_WAIT) begin
                    if ((ext_md && trg_edge) || (!ext_md && c_exec)) begin
                        idx_ff   <= start_c; // [RQ18]
                        tmr_ff   <= dwell_c;
                        state_ff <= ST_RUN;
                    end
                end else if (tmr_ff <= 32'h1) begin
                    tmr_ff <= dwell_c; // [RQ1]
                    if (at_end && mode != `FLLS_MODE_AUTO) begin
                        state_ff <= ST_WAIT; // [RQ18]
                    end else begin
                        idx_ff <= idx_nx; // [RQ17]
                    end
                end else begin
                    tmr_ff <= tmr_ff - 1'b1; // [RQ1] [RQ4]
                end
            end
            endcase
        end
    end

    // Output registers follow the current entry
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ofreq_ff <= 32'h0;
            olvl_ff  <= 16'h0;
            ohws_ff  <= 16'h0;
        end else if (state_ff == ST_RUN || state_ff == ST_WAIT) begin
            ofreq_ff <= freq_mem[idx_ff]; // [RQ6]
            olvl_ff  <= lvl_mem[idx_ff];
            ohws_ff  <= hws_mem[idx_ff];
        end
    end

    assign o_wb_ack     = ack_ff;
    assign o_wb_dat     = rdat_ff;
    assign o_freq       = ofreq_ff;
    assign o_level      = olvl_ff;
    assign o_hw_setting = ohws_ff;
    assign o_busy       = (state_ff == ST_RUN);
    // Settled once the settling share of the dwell has passed
    assign o_settled    = (state_ff == ST_RUN) && !step_md
                        && (dwell_c - tmr_ff >= {24'h0, `FLLS_HW_SETTLE}); // [RQ4]
endmodule

// [sim/flls_top_asserts.sv]
`timescale 1ns/10ps
module flls_chk (
    input wire        i_clk,
    input wire        i_arst_n,
    input wire        i_wb_cyc,
    input wire        i_wb_stb,
    input wire        i_wb_we,
    input wire [7:0]  i_wb_adr,
    input wire [3:0]  i_wb_sel,
    input wire [31:0] i_wb_dat,
    input wire [31:0] o_wb_dat,
    input wire        o_wb_ack,
    input wire        i_instrument_trigger_input,
    input wire [31:0] o_freq,
    input wire [15:0] o_level,
    input wire [15:0] o_hw_setting,
    input wire        o_busy,
    input wire        o_settled
);
    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    a_ack_latency: assert property (s_req |=> o_wb_ack)
        else $error("ack late");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    a_idle_no_ack: assert property (!i_wb_cyc [*2] |-> !o_wb_ack)
        else $error("ack while bus idle");
    a_rdata_hold: assert property (!(i_wb_cyc && i_wb_stb && !i_wb_we) |=> $stable(o_wb_dat))
        else $error("read data moved without read");
    a_settle_busy: assert property (o_settled |-> o_busy)
        else $error("settled outside run");
    a_run_unsettled: assert property ($rose(o_busy) |-> !o_settled)
        else $error("settled at run start");
    a_settle_late: assert property ($rose(o_settled) |-> $past(o_busy, 3))
        else $error("settled too early");
    a_hw_level: assert property (o_busy && $past(o_busy) |-> o_hw_setting == o_level + 16'h0004)
        else $error("hardware setting wrong");
    c_write: cover property (o_wb_ack && i_wb_we);
    c_run: cover property ($rose(o_busy));
    c_settle: cover property ($rose(o_settled));
endmodule

bind flls_top flls_chk flls_chk_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_freq(o_freq), .o_level(o_level),
    .i_instrument_trigger_input(i_instrument_trigger_input), .o_hw_setting(o_hw_setting),
    .o_busy(o_busy), .o_settled(o_settled)
);

// [sim/flls_trig_src.sv]
`timescale 1ns/10ps
module flls_trig_src (
    // Clock and trigger pin
    input  wire i_clk,
    output reg  o_trig
);
    initial o_trig = 1'b0;
    // Idle at the inactive level; moving it is an edge the block must ignore
    task set_idle(input n);
        begin
            @(posedge i_clk);
            o_trig <= n;
        end
    endtask
    task pulse(input n);
        begin
            @(posedge i_clk);
            o_trig <= !n;
            repeat (3) @(posedge i_clk);
            o_trig <= n;
        end
    endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/10ps
`include "flls_consts.vh"
module tb_top;
    logic        i_clk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic [3:0]  wsel = 4'hF;
    logic [31:0] r;
    logic [31:0] f;
    wire  [31:0] o_wb_dat;
    wire         o_wb_ack;
    wire         trig;
    wire  [31:0] o_freq;
    wire  [15:0] o_level;
    wire  [15:0] o_hw_setting;
    wire         o_busy;
    wire         o_settled;
    integer      errors = 0;
    integer      n_checks = 0;
    integer      i;
    integer      c;
    always #10 i_clk = ~i_clk;
    flls_top flls_top_i (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .i_instrument_trigger_input(trig), .o_freq(o_freq),
        .o_level(o_level), .o_hw_setting(o_hw_setting), .o_busy(o_busy), .o_settled(o_settled)
    );
    flls_trig_src flls_trig_src_i (.i_clk(i_clk), .o_trig(trig));
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, errors);
            if (errors == 0 && n_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input [31:0] s, input [31:0] e);
        begin
            n_checks = n_checks + 1;
            if (s !== e) begin
                errors = errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, s, e);
            end
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge i_clk);
            {cyc, stb, we} <= {2'b11, w};
            sel <= wsel;
            adr <= a;
            dat <= d;
            n = 0;
            @(posedge i_clk);
            while (o_wb_ack !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge i_clk);
            end
            if (n == 20)
                errors = errors + 1;
            r = o_wb_dat;
            {cyc, stb, we} <= 3'b000;
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            wb(1'b0, a, 32'h0);
            chk(r, e);
        end
    endtask
    // Edits and learning take a variable time, so poll the status
    task settle_wait;
        integer k;
        begin
            k = 0;
            r = 32'h0000_0011;
            while ((r[4] || r[2:0] == 3'h1) && k < 100) begin
                wb(1'b0, `FLLS_REG_STATUS, 32'h0);
                k = k + 1;
            end
        end
    endtask
    task cmd(input [31:0] d);
        begin
            wb(1'b1, `FLLS_REG_CMD, d);
            settle_wait;
        end
    endtask
    task wchg(output integer cnt);
        logic [31:0] p;
        begin
            p = o_freq;
            cnt = 0;
            while (o_freq === p && cnt < 300) begin
                @(posedge i_clk);
                cnt = cnt + 1;
            end
        end
    endtask
    initial begin
        #400000;
        errors = errors + 1;
        end_of_test;
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rdc(`FLLS_REG_DWELL, `FLLS_DWELL_RST);
        rdc(`FLLS_REG_RANGE, 32'h003F_0000);
        rdc(`FLLS_REG_LENGTH, 32'h0);
        rdc(8'h3C, 32'h0);
        $display("done: reset values");
        // Command lane not selected, so the insert must not happen
        wsel = 4'hE;
        cmd(32'h0000_0408);
        rdc(`FLLS_REG_LENGTH, 32'h0);
        wsel = 4'hF;
        cmd(32'h0000_0408);
        rdc(`FLLS_REG_LENGTH, 32'h4);
        for (i = 0; i < 4; i = i + 1) begin
            wb(1'b1, `FLLS_REG_EDIT_ADDR, i);
            wb(1'b1, `FLLS_REG_FREQ, 100 + i);
            wb(1'b1, `FLLS_REG_LEVEL, i);
            cmd(32'h0000_0040);
        end
        wb(1'b1, `FLLS_REG_EDIT_ADDR, 32'h1);
        cmd(32'h0000_0108);
        rdc(`FLLS_REG_LENGTH, 32'h5);
        wb(1'b1, `FLLS_REG_EDIT_ADDR, 32'h2);
        rdc(`FLLS_REG_FREQ, 32'd101);
        wb(1'b1, `FLLS_REG_EDIT_ADDR, 32'h1);
        cmd(32'h0000_0110);
        rdc(`FLLS_REG_LENGTH, 32'h4);
        rdc(`FLLS_REG_FREQ, 32'd101);
        // Past the end of the table, so refused
        wb(1'b1, `FLLS_REG_EDIT_ADDR, 32'h3);
        cmd(32'h0000_0210);
        rdc(`FLLS_REG_LENGTH, 32'h4);
        $display("done: insert and delete");
        wb(1'b1, `FLLS_REG_FILL_CFG, 32'h0000_0080);
        wb(1'b1, `FLLS_REG_FILL_ST, 32'd10);
        wb(1'b1, `FLLS_REG_FILL_INC, 32'd3);
        wb(1'b1, `FLLS_REG_EDIT_ADDR, 32'h0);
        rdc(`FLLS_REG_LEVEL, 32'h0);
        cmd(32'h0000_0420);
        for (i = 0; i < 4; i = i + 1) begin
            wb(1'b1, `FLLS_REG_EDIT_ADDR, i);
            rdc(`FLLS_REG_LEVEL, 10 + 3 * i);
            rdc(`FLLS_REG_FREQ, 100 + i);
        end
        $display("done: fill");
        wb(1'b1, `FLLS_REG_CTRL, 32'h05);
        settle_wait;
        chk(r[7], 32'h1);
        wb(1'b1, `FLLS_REG_INDEX, 32'h2);
        repeat (3) @(posedge i_clk);
        chk(o_freq, 32'd102);
        chk(o_hw_setting, 32'd20);
        chk(o_level, 32'd16);
        wb(1'b1, `FLLS_REG_INDEX, 32'h9);
        rdc(`FLLS_REG_INDEX, 32'h3);
        $display("done: manual step");
        wb(1'b1, `FLLS_REG_CTRL, 32'h0);
        wb(1'b1, `FLLS_REG_DWELL, 32'd8);
        wb(1'b1, `FLLS_REG_RANGE, 32'h0002_0001);
        wb(1'b1, `FLLS_REG_CTRL, 32'h09);
        rdc(`FLLS_REG_STATUS, 32'h0000_0083);
        cmd(32'h1);
        rdc(`FLLS_REG_INDEX, 32'h1);
        flls_trig_src_i.pulse(1'b0);
        repeat (3) @(posedge i_clk);
        rdc(`FLLS_REG_INDEX, 32'h2);
        chk(o_freq, 32'd102);
        repeat (30) @(posedge i_clk);
        rdc(`FLLS_REG_INDEX, 32'h2);
        wb(1'b1, `FLLS_REG_CTRL, 32'h0);
        wb(1'b1, `FLLS_REG_CTRL, 32'h19);
        cmd(32'h1);
        flls_trig_src_i.set_idle(1'b1);
        repeat (3) @(posedge i_clk);
        rdc(`FLLS_REG_INDEX, 32'h1);
        flls_trig_src_i.pulse(1'b1);
        repeat (3) @(posedge i_clk);
        rdc(`FLLS_REG_INDEX, 32'h2);
        cmd(32'h1);
        rdc(`FLLS_REG_INDEX, 32'h1);
        $display("done: external step");
        wb(1'b1, `FLLS_REG_CTRL, 32'h0);
        flls_trig_src_i.set_idle(1'b0);
        wb(1'b1, `FLLS_REG_CTRL, 32'h01);
        wchg(c);
        wchg(c);
        f = o_freq;
        for (i = 0; i < 3; i = i + 1) begin
            wchg(c);
            chk(c, 32'd8);
            chk(o_freq, 32'd203 - f);
            f = o_freq;
        end
        $display("done: auto");
        wb(1'b1, `FLLS_REG_CTRL, 32'h0);
        wb(1'b1, `FLLS_REG_CTRL, 32'h03);
        repeat (20) @(posedge i_clk);
        chk(o_busy, 32'h0);
        cmd(32'h2);
        chk(o_busy, 32'h1);
        chk(o_settled, 32'h0);
        @(posedge i_clk);
        chk(o_settled, 32'h1);
        repeat (40) @(posedge i_clk);
        chk(o_busy, 32'h0);
        chk(o_freq, 32'd102);
        wb(1'b1, `FLLS_REG_CTRL, 32'h0);
        wb(1'b1, `FLLS_REG_CTRL, 32'h07);
        flls_trig_src_i.pulse(1'b0);
        repeat (2) @(posedge i_clk);
        chk(o_busy, 32'h1);
        $display("done: single passes");
        end_of_test;
    end
endmodule
